// ---- sync_serial_pkg.sv ----
package sync_serial_pkg;

	// ****************************************
	// word and buffer shape
	// ****************************************
	localparam int WORD_BITS = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int BIT_CNT_W = 5;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic RST_CLOCK_SOURCE_SELECT = 1'b0;
	localparam logic RST_FRAME_SYNC_DIRECTION = 1'b0;
	localparam logic RST_PORT_ENABLE = 1'b0;
	localparam logic RST_OUTPUT_DISABLE_N = 1'b1;
	localparam logic RST_FRAME_SYNC_LEVEL = 1'b1;
	localparam logic RST_DATA_OUT = 1'b0;
	localparam logic [WORD_BITS-1:0] RST_WORD = 16'h0000;
	localparam logic [BIT_CNT_W-1:0] RST_BIT_CNT = 5'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	// internal transmit bit clock toggles every machine clock: half rate
	localparam int TX_DIV_TOGGLE_CYCLES = 1;

	// ****************************************
	// state machines
	// ****************************************
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_SYNC,
		TX_SHIFT
	} tx_state_t;

endpackage : sync_serial_pkg

// ---- word_fifo_if.sv ----
`timescale 1ns/1ps
interface word_fifo_if #(
	parameter int WIDTH = 16
);
	logic [WIDTH-1:0] wr_data;
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] rd_data;
	logic rd_valid;
	logic rd_ready;

	modport fifo (
		input wr_data,
		input wr_valid,
		output wr_ready,
		output rd_data,
		output rd_valid,
		input rd_ready
	);

	modport user (
		output wr_data,
		output wr_valid,
		input wr_ready,
		input rd_data,
		input rd_valid,
		output rd_ready
	);
endinterface : word_fifo_if

// ---- word_fifo.sv ----
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	word_fifo_if.fifo port
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] nxt_wr_ptr;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW-1:0] nxt_rd_ptr;
	logic [CW-1:0] count_ff;
	logic [CW-1:0] nxt_count;
	logic wr_ready_ff;
	logic nxt_wr_ready;
	logic rd_valid_ff;
	logic nxt_rd_valid;
	logic do_wr;
	logic do_rd;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	// ready and valid are registered flags, so full and empty are exact
	always_comb begin
		do_wr = port.wr_valid && wr_ready_ff;
		do_rd = port.rd_ready && rd_valid_ff;
		nxt_wr_ptr = do_wr ? bump(wr_ptr_ff) : wr_ptr_ff;
		nxt_rd_ptr = do_rd ? bump(rd_ptr_ff) : rd_ptr_ff;
		nxt_count = count_ff;
		if (do_wr && !do_rd) begin
			nxt_count = count_ff + 1'b1;
		end else if (do_rd && !do_wr) begin
			nxt_count = count_ff - 1'b1;
		end
		nxt_wr_ready = (nxt_count != CW'(DEPTH));
		nxt_rd_valid = (nxt_count != '0);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			wr_ready_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
			wr_ready_ff <= nxt_wr_ready;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	// storage has no reset; only slots holding unread words, from rd_ptr_ff on, are ever read
	always_ff @(posedge i_clk) begin
		if (do_wr) begin
			mem[wr_ptr_ff] <= port.wr_data;
		end
	end

	assign port.wr_ready = wr_ready_ff;
	assign port.rd_valid = rd_valid_ff;
	assign port.rd_data = mem[rd_ptr_ff];
endmodule : word_fifo

// ---- sync_serial_port.sv ----
// Functional notes
// - select 0: transmit clock pin is input
// - select 1: drive transmit clock at half rate
// - transmit clock pin input after reset
// - shift transmit word out on data pin
// - shift data pin into receive register
// - idle port: receive clock level readable
// - transmit frame sync fall starts transmit
// - frame sync input until direction bit set
// - receive frame sync fall starts receive
// - output disable floats data, sync, clock
// - output disable releases every output driver
`timescale 1ns/1ps
module sync_serial_port #(
	parameter int WORD_BITS = sync_serial_pkg::WORD_BITS,
	parameter int FIFO_DEPTH = sync_serial_pkg::FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_clock_source_select,
	input wire logic i_frame_sync_direction,
	input wire logic i_port_enable,
	input wire logic i_output_disable_n,
	input wire logic [WORD_BITS-1:0] i_tx_word,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic [WORD_BITS-1:0] o_rx_word,
	output logic o_rx_valid,
	output logic o_receive_clock_sample_bit,
	input wire logic i_transmit_bit_clock,
	output logic o_transmit_bit_clock,
	output logic o_transmit_bit_clock_oe,
	input wire logic i_transmit_frame_sync,
	output logic o_transmit_frame_sync,
	output logic o_transmit_frame_sync_oe,
	output logic o_serial_data_out,
	output logic o_serial_data_out_oe,
	input wire logic i_receive_bit_clock,
	input wire logic i_receive_frame_sync,
	input wire logic i_serial_data_in
);
	import sync_serial_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic fell(input logic prev, input logic cur);
		fell = prev && !cur;
	endfunction : fell

	function automatic logic rose(input logic prev, input logic cur);
		rose = !prev && cur;
	endfunction : rose

	// ****************************************
	// transmit word buffer
	// ****************************************
	word_fifo_if #(.WIDTH(WORD_BITS)) txq ();

	word_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.port(txq.fifo)
	);

	assign txq.wr_data = i_tx_word;
	assign txq.wr_valid = i_tx_valid;
	assign o_tx_ready = txq.wr_ready;

	// ****************************************
	// configuration and pin synchronisers
	// ****************************************
	logic clk_src_ff;
	logic fs_dir_ff;
	logic port_en_ff;
	logic off_n_meta_ff;
	logic off_n_ff;
	logic txc_meta_ff;
	logic txc_sync_ff;
	logic txc_prev_ff;
	logic fsx_meta_ff;
	logic fsx_sync_ff;
	logic fsx_prev_ff;
	logic rxc_meta_ff;
	logic rxc_sync_ff;
	logic rxc_sample_ff;
	logic nxt_rxc_sample;

	// control levels come from same-clock logic; pins pass two flops
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			clk_src_ff <= RST_CLOCK_SOURCE_SELECT;
			fs_dir_ff <= RST_FRAME_SYNC_DIRECTION;
			port_en_ff <= RST_PORT_ENABLE;
			off_n_meta_ff <= RST_OUTPUT_DISABLE_N;
			off_n_ff <= RST_OUTPUT_DISABLE_N;
			txc_meta_ff <= 1'b0;
			txc_sync_ff <= 1'b0;
			txc_prev_ff <= 1'b0;
			fsx_meta_ff <= RST_FRAME_SYNC_LEVEL;
			fsx_sync_ff <= RST_FRAME_SYNC_LEVEL;
			fsx_prev_ff <= RST_FRAME_SYNC_LEVEL;
			rxc_meta_ff <= 1'b0;
			rxc_sync_ff <= 1'b0;
			rxc_sample_ff <= 1'b0;
		end else begin
			clk_src_ff <= i_clock_source_select;
			fs_dir_ff <= i_frame_sync_direction;
			port_en_ff <= i_port_enable;
			off_n_meta_ff <= i_output_disable_n;
			off_n_ff <= off_n_meta_ff;
			txc_meta_ff <= i_transmit_bit_clock;
			txc_sync_ff <= txc_meta_ff;
			txc_prev_ff <= txc_sync_ff;
			fsx_meta_ff <= i_transmit_frame_sync;
			fsx_sync_ff <= fsx_meta_ff;
			fsx_prev_ff <= fsx_sync_ff;
			rxc_meta_ff <= i_receive_bit_clock;
			rxc_sync_ff <= rxc_meta_ff;
			rxc_sample_ff <= nxt_rxc_sample;
		end
	end

	// sample bit freezes while the port is in use
	always_comb begin
		nxt_rxc_sample = port_en_ff ? rxc_sample_ff : rxc_sync_ff;
	end

	assign o_receive_clock_sample_bit = rxc_sample_ff;

	// ****************************************
	// transmit bit clock
	// ****************************************
	logic div_ff;
	logic nxt_div;
	logic bit_tick;

	// external clock is oversampled, so it must stay below a quarter of i_clk
	always_comb begin
		nxt_div = clk_src_ff ? !div_ff : 1'b0;
		if (clk_src_ff) begin
			bit_tick = !div_ff;
		end else begin
			bit_tick = rose(txc_prev_ff, txc_sync_ff);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
		end
	end

	// ****************************************
	// transmit engine
	// ****************************************
	tx_state_t tx_state_ff;
	tx_state_t nxt_tx_state;
	logic [WORD_BITS-1:0] tx_shreg_ff;
	logic [WORD_BITS-1:0] nxt_tx_shreg;
	logic [BIT_CNT_W-1:0] tx_cnt_ff;
	logic [BIT_CNT_W-1:0] nxt_tx_cnt;
	logic fsx_out_ff;
	logic nxt_fsx_out;
	logic pend_ff;
	logic nxt_pend;
	logic dout_ff;
	logic nxt_dout;
	logic pop;
	logic [WORD_BITS-1:0] load_word;

	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_shreg = tx_shreg_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_fsx_out = fsx_out_ff;
		nxt_pend = pend_ff;
		nxt_dout = dout_ff;
		pop = 1'b0;
		// an empty buffer at a peer-made frame sends zeros
		load_word = txq.rd_valid ? txq.rd_data : RST_WORD;
		case (tx_state_ff)
			TX_IDLE: begin
				if (!fs_dir_ff && port_en_ff && fell(fsx_prev_ff, fsx_sync_ff)) begin
					nxt_pend = 1'b1;
				end
				if (fs_dir_ff) begin
					nxt_pend = 1'b0;
					if (port_en_ff && txq.rd_valid && bit_tick) begin
						nxt_fsx_out = 1'b0;
						nxt_tx_state = TX_SYNC;
					end
				end else if (pend_ff && bit_tick) begin
					nxt_pend = 1'b0;
					pop = txq.rd_valid;
					nxt_dout = load_word[WORD_BITS-1];
					nxt_tx_shreg = load_word << 1;
					nxt_tx_cnt = BIT_CNT_W'(WORD_BITS - 1);
					nxt_tx_state = TX_SHIFT;
				end
			end
			TX_SYNC: begin
				if (bit_tick) begin
					nxt_fsx_out = RST_FRAME_SYNC_LEVEL;
					pop = txq.rd_valid;
					nxt_dout = load_word[WORD_BITS-1];
					nxt_tx_shreg = load_word << 1;
					nxt_tx_cnt = BIT_CNT_W'(WORD_BITS - 1);
					nxt_tx_state = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (bit_tick) begin
					if (tx_cnt_ff == RST_BIT_CNT) begin
						nxt_dout = RST_DATA_OUT;
						nxt_tx_state = TX_IDLE;
					end else begin
						nxt_dout = tx_shreg_ff[WORD_BITS-1];
						nxt_tx_shreg = tx_shreg_ff << 1;
						nxt_tx_cnt = tx_cnt_ff - 1'b1;
					end
				end
			end
			default: begin
				nxt_tx_state = TX_IDLE;
				nxt_fsx_out = RST_FRAME_SYNC_LEVEL;
				nxt_dout = RST_DATA_OUT;
			end
		endcase
	end

	assign txq.rd_ready = pop;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_state_ff <= TX_IDLE;
			tx_shreg_ff <= RST_WORD;
			tx_cnt_ff <= RST_BIT_CNT;
			fsx_out_ff <= RST_FRAME_SYNC_LEVEL;
			pend_ff <= 1'b0;
			dout_ff <= RST_DATA_OUT;
		end else begin
			tx_state_ff <= nxt_tx_state;
			tx_shreg_ff <= nxt_tx_shreg;
			tx_cnt_ff <= nxt_tx_cnt;
			fsx_out_ff <= nxt_fsx_out;
			pend_ff <= nxt_pend;
			dout_ff <= nxt_dout;
		end
	end

	// ****************************************
	// transmit pin drivers
	// ****************************************
	logic txc_oe_ff;
	logic nxt_txc_oe;
	logic fsx_oe_ff;
	logic nxt_fsx_oe;
	logic dx_oe_ff;
	logic nxt_dx_oe;

	// enables are registered so every pin output comes from a flop
	always_comb begin
		nxt_txc_oe = clk_src_ff && off_n_ff;
		nxt_fsx_oe = fs_dir_ff && off_n_ff;
		nxt_dx_oe = off_n_ff;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			txc_oe_ff <= 1'b0;
			fsx_oe_ff <= 1'b0;
			dx_oe_ff <= 1'b0;
		end else begin
			txc_oe_ff <= nxt_txc_oe;
			fsx_oe_ff <= nxt_fsx_oe;
			dx_oe_ff <= nxt_dx_oe;
		end
	end

	assign o_transmit_bit_clock = div_ff;
	assign o_transmit_bit_clock_oe = txc_oe_ff;
	assign o_transmit_frame_sync = fsx_out_ff;
	assign o_transmit_frame_sync_oe = fsx_oe_ff;
	assign o_serial_data_out = dout_ff;
	assign o_serial_data_out_oe = dx_oe_ff;

	// ****************************************
	// receive engine (link clock domain)
	// ****************************************
	logic fsr_prev_rx_ff;
	logic rx_busy_rx_ff;
	logic nxt_rx_busy_rx;
	logic [WORD_BITS-1:0] rx_shreg_rx_ff;
	logic [WORD_BITS-1:0] nxt_rx_shreg_rx;
	logic [BIT_CNT_W-1:0] rx_cnt_rx_ff;
	logic [BIT_CNT_W-1:0] nxt_rx_cnt_rx;
	logic [WORD_BITS-1:0] rx_hold_rx_ff;
	logic [WORD_BITS-1:0] nxt_rx_hold_rx;
	logic rx_tog_rx_ff;
	logic nxt_rx_tog_rx;

	// the link clock only ticks while the peer sends, so a word ends on its last bit
	always_comb begin
		nxt_rx_busy_rx = rx_busy_rx_ff;
		nxt_rx_shreg_rx = rx_shreg_rx_ff;
		nxt_rx_cnt_rx = rx_cnt_rx_ff;
		nxt_rx_hold_rx = rx_hold_rx_ff;
		nxt_rx_tog_rx = rx_tog_rx_ff;
		if (!rx_busy_rx_ff && fell(fsr_prev_rx_ff, i_receive_frame_sync)) begin
			nxt_rx_busy_rx = 1'b1;
			nxt_rx_shreg_rx = {rx_shreg_rx_ff[WORD_BITS-2:0], i_serial_data_in};
			nxt_rx_cnt_rx = BIT_CNT_W'(WORD_BITS - 2);
		end else if (rx_busy_rx_ff) begin
			nxt_rx_shreg_rx = {rx_shreg_rx_ff[WORD_BITS-2:0], i_serial_data_in};
			nxt_rx_cnt_rx = rx_cnt_rx_ff - 1'b1;
			if (rx_cnt_rx_ff == RST_BIT_CNT) begin
				nxt_rx_busy_rx = 1'b0;
				nxt_rx_hold_rx = {rx_shreg_rx_ff[WORD_BITS-2:0], i_serial_data_in};
				nxt_rx_tog_rx = !rx_tog_rx_ff;
			end
		end
	end

	always_ff @(posedge i_receive_bit_clock or posedge i_rst) begin
		if (i_rst) begin
			fsr_prev_rx_ff <= RST_FRAME_SYNC_LEVEL;
			rx_busy_rx_ff <= 1'b0;
			rx_shreg_rx_ff <= RST_WORD;
			rx_cnt_rx_ff <= RST_BIT_CNT;
			rx_hold_rx_ff <= RST_WORD;
			rx_tog_rx_ff <= 1'b0;
		end else begin
			fsr_prev_rx_ff <= i_receive_frame_sync;
			rx_busy_rx_ff <= nxt_rx_busy_rx;
			rx_shreg_rx_ff <= nxt_rx_shreg_rx;
			rx_cnt_rx_ff <= nxt_rx_cnt_rx;
			rx_hold_rx_ff <= nxt_rx_hold_rx;
			rx_tog_rx_ff <= nxt_rx_tog_rx;
		end
	end

	// ****************************************
	// receive word crossing into i_clk
	// ****************************************
	logic tog_meta_ff;
	logic tog_sync_ff;
	logic tog_prev_ff;
	logic [WORD_BITS-1:0] rx_word_ff;
	logic [WORD_BITS-1:0] nxt_rx_word;
	logic rx_valid_ff;
	logic nxt_rx_valid;

	// hold word is stable for a whole frame after the toggle, so it is safe to copy
	always_comb begin
		nxt_rx_valid = tog_sync_ff ^ tog_prev_ff;
		nxt_rx_word = nxt_rx_valid ? rx_hold_rx_ff : rx_word_ff;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tog_meta_ff <= 1'b0;
			tog_sync_ff <= 1'b0;
			tog_prev_ff <= 1'b0;
			rx_word_ff <= RST_WORD;
			rx_valid_ff <= 1'b0;
		end else begin
			tog_meta_ff <= rx_tog_rx_ff;
			tog_sync_ff <= tog_meta_ff;
			tog_prev_ff <= tog_sync_ff;
			rx_word_ff <= nxt_rx_word;
			rx_valid_ff <= nxt_rx_valid;
		end
	end

	assign o_rx_word = rx_word_ff;
	assign o_rx_valid = rx_valid_ff;
endmodule : sync_serial_port

// ---- sync_serial_port_sva.sv ----
`timescale 1ns/1ps
// ****
// pin checks
// ****
module sync_serial_port_sva #(
	parameter int WORD_BITS = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_clock_source_select,
	input wire logic i_frame_sync_direction,
	input wire logic i_port_enable,
	input wire logic i_output_disable_n,
	input wire logic [WORD_BITS-1:0] o_rx_word,
	input wire logic o_rx_valid,
	input wire logic o_receive_clock_sample_bit,
	input wire logic i_receive_bit_clock,
	input wire logic o_transmit_bit_clock,
	input wire logic o_transmit_bit_clock_oe,
	input wire logic o_transmit_frame_sync,
	input wire logic o_transmit_frame_sync_oe,
	input wire logic o_serial_data_out,
	input wire logic o_serial_data_out_oe
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_clk_oe_src: assert property (o_transmit_bit_clock_oe |-> $past(i_clock_source_select, 2))
		else $error("transmit clock driven while external");
	a_clk_half_rate: assert property ((i_clock_source_select && $past(i_clock_source_select, 3))
		|-> o_transmit_bit_clock != $past(o_transmit_bit_clock))
		else $error("internal transmit clock not at half rate");
	a_fs_oe_dir: assert property (o_transmit_frame_sync_oe |-> $past(i_frame_sync_direction, 2))
		else $error("frame sync driven while input");
	a_off_floats: assert property ((!i_output_disable_n)[*4]
		|-> !(o_serial_data_out_oe || o_transmit_frame_sync_oe || o_transmit_bit_clock_oe))
		else $error("driver still on while disabled");
	a_data_drives: assert property (i_output_disable_n[*5] |-> o_serial_data_out_oe)
		else $error("data pin not driven");
	a_fs_pulse: assert property ($fell(o_transmit_frame_sync) |=> !o_transmit_frame_sync ##1 o_transmit_frame_sync)
		else $error("frame sync low not one bit period");
	a_idle_data: assert property ($fell(o_transmit_frame_sync) |-> !o_serial_data_out)
		else $error("data not idle at frame start");
	a_rx_one_cycle: assert property (o_rx_valid |=> !o_rx_valid)
		else $error("receive valid longer than one cycle");
	a_rx_word_held: assert property (!o_rx_valid |-> $stable(o_rx_word))
		else $error("receive word changed without valid");
	a_sample_frozen: assert property ((i_port_enable && $past(i_port_enable)) |-> $stable(o_receive_clock_sample_bit))
		else $error("sample bit moved while port in use");
	a_sample_tracks: assert property ((!i_port_enable && i_receive_bit_clock)[*4] |-> o_receive_clock_sample_bit)
		else $error("sample bit misses receive clock level");

	c_tx_frame: cover property ($fell(o_transmit_frame_sync));
	c_rx_word: cover property (o_rx_valid);
	c_off: cover property ((!i_output_disable_n)[*4]);
endmodule : sync_serial_port_sva

// ---- codec_peer.sv ----
`timescale 1ns/1ps
// ****
// serial peer
// ****
module codec_peer (
	output logic o_receive_bit_clock,
	output logic o_receive_frame_sync,
	output logic o_serial_data_in
);
	initial begin
		o_receive_bit_clock = 1'b0;
		o_receive_frame_sync = 1'b1;
		o_serial_data_in = 1'b0;
	end

	// link clock 15 ns, runs only inside frames
	task automatic tick();
		#7.5 o_receive_bit_clock = 1'b1;
		#7.5 o_receive_bit_clock = 1'b0;
	endtask : tick

	task automatic send_word(input logic [15:0] w);
		tick();
		for (int i = 15; i >= 0; i--) begin
			o_receive_frame_sync = (i != 15);
			o_serial_data_in = w[i];
			tick();
		end
		o_receive_frame_sync = 1'b1;
		// released line: inverse so a stale bit cannot pass
		o_serial_data_in = ~w[0];
	endtask : send_word

	task automatic park(input logic lvl);
		o_receive_bit_clock = lvl;
	endtask : park
endmodule : codec_peer

// ---- tb_top.sv ----
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_top;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic sel = 1'b0, dir = 1'b0, en = 1'b0, dis_n = 1'b1, tx_valid = 1'b0;
	logic [15:0] tx_word = 16'h0000;
	logic [15:0] rx_word;
	logic tx_ready, rx_valid, sample, tclk_o, tclk_oe, tfs_o, tfs_oe, dout, dout_oe, rclk, rfs, din;
	// external side idles clock low, frame sync high
	logic ext_clk = 1'b0;
	logic ext_fs = 1'b1;
	wire tclk_pin = tclk_oe ? tclk_o : ext_clk;
	wire tfs_pin = tfs_oe ? tfs_o : ext_fs;
	logic [15:0] txq[$];
	logic [15:0] rxq[$];
	int failures = 0;
	int compares = 0;
	logic [31:0] seed = 32'ha479;

	always #50 i_clk = ~i_clk;

	sync_serial_port dut (.i_clk(i_clk), .i_rst(i_rst), .i_clock_source_select(sel),
		.i_frame_sync_direction(dir), .i_port_enable(en), .i_output_disable_n(dis_n),
		.i_tx_word(tx_word), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_word(rx_word),
		.o_rx_valid(rx_valid), .o_receive_clock_sample_bit(sample), .i_transmit_bit_clock(tclk_pin),
		.o_transmit_bit_clock(tclk_o), .o_transmit_bit_clock_oe(tclk_oe), .i_transmit_frame_sync(tfs_pin),
		.o_transmit_frame_sync(tfs_o), .o_transmit_frame_sync_oe(tfs_oe), .o_serial_data_out(dout),
		.o_serial_data_out_oe(dout_oe), .i_receive_bit_clock(rclk), .i_receive_frame_sync(rfs),
		.i_serial_data_in(din));
	codec_peer peer (.o_receive_bit_clock(rclk), .o_receive_frame_sync(rfs), .o_serial_data_in(din));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	// valid stays up so back-to-back words need no gap
	task automatic push(input logic [15:0] w);
		int n;
		n = 0;
		tx_word <= w;
		tx_valid <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (tx_ready !== 1'b1 && n < 100);
		if (tx_ready !== 1'b1) begin
			failures++;
			end_sim();
		end
		txq.push_back(w);
	endtask : push

	initial begin : tx_mon
		logic [15:0] w;
		forever begin
			@(posedge i_clk);
			#1;
			if (tfs_oe === 1'b1 && tfs_o === 1'b0) begin
				for (int i = 15; i >= 0; i--) begin
					repeat (2) @(posedge i_clk);
					#1;
					w[i] = dout;
				end
				check(w, txq.size() ? txq.pop_front() : ~w);
			end
		end
	end

	// look after the launching edge has settled
	always @(posedge i_clk) begin
		#1;
		if (rx_valid === 1'b1)
			check(rx_word, rxq.size() ? rxq.pop_front() : ~rx_word);
	end

	initial begin
		int n;
		logic [15:0] w;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		check(tclk_oe, 1'b0);
		check(tfs_oe, 1'b0);
		check(dout_oe, 1'b0);
		$display("test reset done");
		sel <= 1'b1;
		dir <= 1'b1;
		// port idle: buffer fills and must refuse more
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			push(seed[15:0]);
		end
		tx_valid <= 1'b0;
		@(posedge i_clk);
		#1;
		check(tx_ready, 1'b0);
		check(tclk_oe, 1'b1);
		check(tfs_oe, 1'b1);
		@(posedge i_clk);
		en <= 1'b1;
		n = 0;
		while (txq.size() != 0 && n < 2000) begin
			@(posedge i_clk);
			n++;
		end
		check(16'(txq.size()), 16'h0000);
		$display("test transmit done");
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			rxq.push_back(seed[15:0]);
			peer.send_word(seed[15:0]);
			#700;
		end
		check(16'(rxq.size()), 16'h0000);
		$display("test receive done");
		@(posedge i_clk);
		dis_n <= 1'b0;
		repeat (5) @(posedge i_clk);
		#1;
		check({dout_oe, tfs_oe, tclk_oe}, 16'h0000);
		@(posedge i_clk);
		dis_n <= 1'b1;
		sel <= 1'b0;
		dir <= 1'b0;
		en <= 1'b0;
		repeat (5) @(posedge i_clk);
		#1;
		check({tfs_oe, tclk_oe}, 16'h0000);
		$display("test disable done");
		peer.park(1'b1);
		repeat (5) @(posedge i_clk);
		#1;
		check(sample, 1'b1);
		@(posedge i_clk);
		en <= 1'b1;
		#1;
		peer.park(1'b0);
		repeat (5) @(posedge i_clk);
		#1;
		check(sample, 1'b1);
		$display("test sample done");
		// peer-made clock and frame sync: slow enough for the pin synchronisers
		seed = lfsr(seed);
		push(seed[15:0]);
		tx_valid <= 1'b0;
		ext_fs <= 1'b0;
		repeat (4) @(posedge i_clk);
		ext_fs <= 1'b1;
		for (int i = 15; i >= 0; i--) begin
			ext_clk <= 1'b1;
			repeat (4) @(posedge i_clk);
			ext_clk <= 1'b0;
			repeat (4) @(posedge i_clk);
			#1;
			w[i] = dout;
		end
		ext_clk <= 1'b1;
		repeat (4) @(posedge i_clk);
		ext_clk <= 1'b0;
		check(w, txq.pop_front());
		check(tclk_oe, 1'b0);
		$display("test external clock done");
		end_sim();
	end
endmodule : tb_top

bind sync_serial_port sync_serial_port_sva #(.WORD_BITS(WORD_BITS)) chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_clock_source_select(i_clock_source_select), .i_frame_sync_direction(i_frame_sync_direction),
	.i_port_enable(i_port_enable), .i_output_disable_n(i_output_disable_n), .o_rx_word(o_rx_word),
	.o_rx_valid(o_rx_valid), .o_receive_clock_sample_bit(o_receive_clock_sample_bit),
	.i_receive_bit_clock(i_receive_bit_clock), .o_transmit_bit_clock(o_transmit_bit_clock),
	.o_transmit_bit_clock_oe(o_transmit_bit_clock_oe), .o_transmit_frame_sync(o_transmit_frame_sync),
	.o_transmit_frame_sync_oe(o_transmit_frame_sync_oe), .o_serial_data_out(o_serial_data_out),
	.o_serial_data_out_oe(o_serial_data_out_oe));
